/* shared/dfi_pkg.sv */
// Package for the format and identify command block
package dfi_pkg;
    localparam logic [7:0] OP_FMT_TRACK = 8'h50;
    localparam logic [7:0] OP_FMT_UNIT = 8'hF7;
    localparam logic [7:0] OP_ERASE_PREP = 8'hF3;
    localparam logic [7:0] OP_IDENTIFY = 8'hEC;
    localparam logic [7:0] FEAT_FMT_UNIT = 8'h11;
    // Register byte addresses on the bus
    localparam logic [7:0] A_DATA = 8'h00;
    localparam logic [7:0] A_FEATURE = 8'h04;
    localparam logic [7:0] A_LBA_LO = 8'h08;
    localparam logic [7:0] A_LBA_MID = 8'h0C;
    localparam logic [7:0] A_LBA_HI = 8'h10;
    localparam logic [7:0] A_DEVHEAD = 8'h14;
    localparam logic [7:0] A_COMMAND = 8'h18;
    localparam logic [7:0] A_ERROR = 8'h1C;
    localparam logic [7:0] A_STATUS = 8'h20;
    localparam logic [7:0] A_CONFIG = 8'h24;
    localparam logic [7:0] A_DEFECT = 8'h28;
    // Error bits
    localparam int ERR_ABORT = 2;
    // Status bits, then the LBA bit of device/head
    localparam int ST_BUSY = 7;
    localparam int ST_READY = 6;
    localparam int ST_SEEK = 4;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    localparam int DH_LBA = 6;
    // Identify contents
    localparam logic [15:0] ID_W0_BASE = 16'h045A;
    localparam logic [15:0] ID_W0_ALT = 16'h045E;
    localparam logic [15:0] ID_W2_SPINUP = 16'h37C8;
    localparam logic [15:0] ID_W6 = 16'h003F;
    localparam logic [15:0] ID_W20 = 16'h0003;
    localparam logic [15:0] ID_W47 = 16'h8010;
    localparam logic [15:0] ID_W49 = 16'h0F00;
    localparam logic [15:0] ID_ASCII_SPACES = 16'h2020;
    localparam logic [7:0] ID_LAST = 8'hFF;
    localparam logic [7:0] W_SERIAL_LO = 8'h0A;
    localparam logic [7:0] W_SERIAL_HI = 8'h13;
    localparam logic [7:0] W_FW_LO = 8'h17;
    localparam logic [7:0] W_FW_HI = 8'h1A;
    localparam logic [7:0] W_MODEL_LO = 8'h1B;
    localparam logic [7:0] W_MODEL_HI = 8'h2E;
    localparam int W49_STBY = 13;
    localparam logic [7:0] W_CLASS = 8'h00;
    localparam logic [7:0] W_SPECIFIC = 8'h02;
    localparam logic [7:0] W_SECTORS = 8'h06;
    localparam logic [7:0] W_CTRL = 8'h14;
    localparam logic [7:0] W_BUF_SIZE = 8'h15;
    localparam logic [7:0] W_MULTI = 8'h2F;
    localparam logic [7:0] W_CAPS = 8'h31;
    // Register reset values
    localparam logic [7:0] ST_RESET = 8'h50;
    localparam logic [7:0] CONFIG_RESET = 8'h01;
    // Geometry, buffer and list sizes
    localparam logic [27:0] NATIVE_MAX_LBA = 28'h0000FFF;
    localparam logic [27:0] TRACK_MASK = 28'hFFFFFC0;
    localparam logic [27:0] TRACK_LEN = 28'h0000040;
    localparam logic [15:0] BUF_UNITS = 16'h0400;
    localparam logic [3:0] DEFECT_DEPTH = 4'h8;

    typedef enum logic [2:0] {
        DFI_IDLE = 3'b000,
        DFI_MERGE = 3'b001,
        DFI_WRITE = 3'b010,
        DFI_IDENT = 3'b011,
        DFI_DONE = 3'b100
    } dfi_state_e;

    typedef struct packed {
        logic [27:0] lba;
        logic fmt_unit;
    } dfi_job_s;
endpackage

/* src/dfi_cmd.sv */
// Format track, format unit and identify command handling with AXI4-Lite registers
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module dfi_cmd (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic sector_we_r,
    output logic [27:0] sector_lba_r,
    output logic [15:0] sector_data_r
);
    dfi_pkg::dfi_state_e state_r;
    dfi_pkg::dfi_job_s job_r;
    logic [7:0] feature_r;
    logic [7:0] lba_lo_r;
    logic [7:0] lba_mid_r;
    logic [7:0] lba_hi_r;
    logic [7:0] devhead_r;
    logic [7:0] error_r;
    logic [7:0] status_r;
    logic [7:0] config_r;
    logic erase_ready_r;
    logic [27:0] end_lba_r;
    logic [7:0] word_r;
    logic [3:0] reassign_cnt_r;
    logic [3:0] defect_cnt_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic aw_held_r;
    logic w_held_r;
    logic wr_fire;
    logic cmd_wr;
    logic data_rd;
    logic [15:0] id_word;
    logic [27:0] host_lba;
    logic wr_ok;
    logic [1:0] rresp_nxt;
    logic [31:0] rdata_nxt;
    logic wstrb_lo_ok;
    logic [3:0] wstrb_r;
    logic [4:0] merge_sum;

    assign host_lba = {devhead_r[3:0], lba_hi_r, lba_mid_r, lba_lo_r};

    // Write channel: address and data may come in either order
    assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
    assign cmd_wr = wr_fire && awaddr_r == dfi_pkg::A_COMMAND && wdata_r[7:0] != 8'h00
        && s_axi_bresp == 2'b00 && wstrb_lo_ok;
    // Task registers are bytes; a write without lane 0 carries nothing, though one to the defect register still counts
    assign wstrb_lo_ok = wstrb_r[0];
    assign wr_ok = awaddr_r == dfi_pkg::A_DATA || awaddr_r == dfi_pkg::A_FEATURE
        || awaddr_r == dfi_pkg::A_LBA_LO || awaddr_r == dfi_pkg::A_LBA_MID
        || awaddr_r == dfi_pkg::A_LBA_HI || awaddr_r == dfi_pkg::A_DEVHEAD
        || awaddr_r == dfi_pkg::A_COMMAND || awaddr_r == dfi_pkg::A_CONFIG
        || awaddr_r == dfi_pkg::A_DEFECT;

    // Ready returns only after the answer is taken: one write in flight
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            aw_held_r <= 1'b0;
            awaddr_r <= 8'h00;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (wr_fire) begin
            aw_held_r <= 1'b0;
        end else if (!aw_held_r && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            w_held_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (wr_fire) begin
            w_held_r <= 1'b0;
        end else if (!w_held_r && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            // Clearing bresp with bvalid keeps a stale error off the next command
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end
    end

    // Task registers; writes while busy are dropped so a running command keeps its inputs
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            feature_r <= 8'h00;
            lba_lo_r <= 8'h00;
            lba_mid_r <= 8'h00;
            lba_hi_r <= 8'h00;
            devhead_r <= 8'h00;
            config_r <= dfi_pkg::CONFIG_RESET;
        end else if (wr_fire && wstrb_r[0] && !status_r[dfi_pkg::ST_BUSY]) begin
            case (awaddr_r)
                dfi_pkg::A_FEATURE: feature_r <= wdata_r[7:0];
                dfi_pkg::A_LBA_LO: lba_lo_r <= wdata_r[7:0];
                dfi_pkg::A_LBA_MID: lba_mid_r <= wdata_r[7:0];
                dfi_pkg::A_LBA_HI: lba_hi_r <= wdata_r[7:0];
                dfi_pkg::A_DEVHEAD: devhead_r <= wdata_r[7:0];
                dfi_pkg::A_CONFIG: config_r <= wdata_r[7:0];
                default: config_r <= config_r;
            endcase
        end else if (state_r == dfi_pkg::DFI_DONE && !job_r.fmt_unit && !error_r[dfi_pkg::ERR_ABORT]) begin
            devhead_r[3:0] <= end_lba_r[27:24];
            lba_hi_r <= end_lba_r[23:16];
            lba_mid_r <= end_lba_r[15:8];
            lba_lo_r <= end_lba_r[7:0];
        end
    end

    // Identify word table
    always_comb begin
        id_word = 16'h0000;
        // Unlisted words read zero; compares cost less than a 256-entry table
        if (word_r == dfi_pkg::W_CLASS) begin
            id_word = config_r[1] ? dfi_pkg::ID_W0_ALT : dfi_pkg::ID_W0_BASE;
        end else if (word_r == dfi_pkg::W_SPECIFIC) begin
            id_word = config_r[0] ? dfi_pkg::ID_W2_SPINUP : 16'h0000;
        end else if (word_r == dfi_pkg::W_SECTORS) begin
            id_word = dfi_pkg::ID_W6;
        end else if ((word_r >= dfi_pkg::W_SERIAL_LO && word_r <= dfi_pkg::W_SERIAL_HI)
                || (word_r >= dfi_pkg::W_FW_LO && word_r <= dfi_pkg::W_MODEL_HI)) begin
            id_word = dfi_pkg::ID_ASCII_SPACES;
        end else if (word_r == dfi_pkg::W_CTRL) begin
            id_word = dfi_pkg::ID_W20;
        end else if (word_r == dfi_pkg::W_BUF_SIZE) begin
            id_word = dfi_pkg::BUF_UNITS;
        end else if (word_r == dfi_pkg::W_MULTI) begin
            id_word = dfi_pkg::ID_W47;
        end else if (word_r == dfi_pkg::W_CAPS) begin
            id_word = dfi_pkg::ID_W49 | ({15'h0000, config_r[2]} << dfi_pkg::W49_STBY);
        end
    end

    assign data_rd = s_axi_arvalid && s_axi_arready && s_axi_araddr == dfi_pkg::A_DATA
        && state_r == dfi_pkg::DFI_IDENT;

    // Command sequencer
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= dfi_pkg::DFI_IDLE;
            job_r <= '0;
            end_lba_r <= 28'h0000000;
            word_r <= 8'h00;
            error_r <= 8'h00;
            status_r <= dfi_pkg::ST_RESET;
            erase_ready_r <= 1'b0;
            sector_we_r <= 1'b0;
            sector_lba_r <= 28'h0000000;
            sector_data_r <= 16'h0000;
        end else begin
            sector_we_r <= 1'b0;
            case (state_r)
                dfi_pkg::DFI_IDLE: begin
                    if (cmd_wr) begin
                        status_r[dfi_pkg::ST_BUSY] <= 1'b1;
                        status_r[dfi_pkg::ST_ERR] <= 1'b0;
                        error_r <= 8'h00;
                        // Any command other than erase-prepare breaks the pairing
                        erase_ready_r <= wdata_r[7:0] == dfi_pkg::OP_ERASE_PREP;
                        state_r <= dfi_pkg::DFI_DONE;
                        if (wdata_r[7:0] == dfi_pkg::OP_FMT_TRACK) begin
                            job_r.fmt_unit <= 1'b0;
                            if (host_lba > dfi_pkg::NATIVE_MAX_LBA) begin
                                error_r[dfi_pkg::ERR_ABORT] <= 1'b1;
                            end else begin
                                job_r.lba <= host_lba & dfi_pkg::TRACK_MASK;
                                end_lba_r <= (host_lba & dfi_pkg::TRACK_MASK) + dfi_pkg::TRACK_LEN
                                    - 28'h0000001;
                                state_r <= dfi_pkg::DFI_WRITE;
                            end
                        end else if (wdata_r[7:0] == dfi_pkg::OP_FMT_UNIT) begin
                            job_r.fmt_unit <= 1'b1;
                            if (!erase_ready_r || feature_r != dfi_pkg::FEAT_FMT_UNIT) begin
                                error_r[dfi_pkg::ERR_ABORT] <= 1'b1;
                            end else begin
                                job_r.lba <= 28'h0000000;
                                end_lba_r <= dfi_pkg::NATIVE_MAX_LBA;
                                state_r <= dfi_pkg::DFI_MERGE;
                            end
                        end else if (wdata_r[7:0] == dfi_pkg::OP_IDENTIFY) begin
                            word_r <= 8'h00;
                            state_r <= dfi_pkg::DFI_IDENT;
                            status_r[dfi_pkg::ST_DRQ] <= 1'b1;
                        end else if (wdata_r[7:0] != dfi_pkg::OP_ERASE_PREP) begin
                            // Unknown opcodes abort; erase-prepare only arms the pairing
                            error_r[dfi_pkg::ERR_ABORT] <= 1'b1;
                        end
                    end
                end
                dfi_pkg::DFI_MERGE: begin
                    state_r <= dfi_pkg::DFI_WRITE;
                end
                dfi_pkg::DFI_WRITE: begin
                    // Zeros only, no read-back; host table never consulted
                    sector_we_r <= 1'b1;
                    sector_lba_r <= job_r.lba;
                    sector_data_r <= 16'h0000;
                    if (job_r.lba == end_lba_r) begin
                        state_r <= dfi_pkg::DFI_DONE;
                    end else begin
                        job_r.lba <= job_r.lba + 28'h0000001;
                    end
                end
                dfi_pkg::DFI_IDENT: begin
                    // Busy drops once the data request is up; the host paces the reads
                    status_r[dfi_pkg::ST_BUSY] <= 1'b0;
                    if (data_rd) begin
                        if (word_r == dfi_pkg::ID_LAST) begin
                            status_r[dfi_pkg::ST_DRQ] <= 1'b0;
                            state_r <= dfi_pkg::DFI_IDLE;
                        end else begin
                            word_r <= word_r + 8'h01;
                        end
                    end
                end
                dfi_pkg::DFI_DONE: begin
                    // Error reaches status on the same edge that drops busy
                    status_r[dfi_pkg::ST_ERR] <= error_r[dfi_pkg::ERR_ABORT];
                    status_r[dfi_pkg::ST_SEEK] <= 1'b1;
                    status_r[dfi_pkg::ST_BUSY] <= 1'b0;
                    state_r <= dfi_pkg::DFI_IDLE;
                end
                default: state_r <= dfi_pkg::DFI_IDLE;
            endcase
        end
    end

    // One bit wider so a merge overflow is seen before clamping
    assign merge_sum = {1'b0, defect_cnt_r} + {1'b0, reassign_cnt_r};

    // Defect and reassignment lists, held across reset by software reload in a real part
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reassign_cnt_r <= 4'h0;
            defect_cnt_r <= 4'h0;
        end else if (state_r == dfi_pkg::DFI_MERGE) begin
            // Reassigned entries merge into the defect list in one step; new ones act at once
            defect_cnt_r <= (merge_sum > {1'b0, dfi_pkg::DEFECT_DEPTH}) ?
                dfi_pkg::DEFECT_DEPTH : merge_sum[3:0];
            reassign_cnt_r <= 4'h0;
        // List saturates at its depth; further reports are dropped
        end else if (wr_fire && awaddr_r == dfi_pkg::A_DEFECT && reassign_cnt_r != dfi_pkg::DEFECT_DEPTH) begin
            reassign_cnt_r <= reassign_cnt_r + 4'h1;
        end
    end

    // Read channel
    always_comb begin
        rresp_nxt = 2'b00;
        rdata_nxt = 32'h0000_0000;
        case (s_axi_araddr)
            dfi_pkg::A_DATA: rdata_nxt = {16'h0000, id_word};
            dfi_pkg::A_FEATURE: rdata_nxt = {24'h000000, feature_r};
            dfi_pkg::A_LBA_LO: rdata_nxt = {24'h000000, lba_lo_r};
            dfi_pkg::A_LBA_MID: rdata_nxt = {24'h000000, lba_mid_r};
            dfi_pkg::A_LBA_HI: rdata_nxt = {24'h000000, lba_hi_r};
            dfi_pkg::A_DEVHEAD: rdata_nxt = {24'h000000, devhead_r};
            dfi_pkg::A_ERROR: rdata_nxt = {24'h000000, error_r};
            dfi_pkg::A_STATUS: rdata_nxt = {24'h000000, status_r};
            dfi_pkg::A_CONFIG: rdata_nxt = {24'h000000, config_r};
            dfi_pkg::A_DEFECT: rdata_nxt = {24'h000000, defect_cnt_r, reassign_cnt_r};
            default: rresp_nxt = 2'b10;
        endcase
    end

    // Data latched at the address handshake stands until rready
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdata_nxt;
            s_axi_rresp <= rresp_nxt;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule

/* verification/dfi_cmd_assertions.sv */
// Checker for the format and identify command block
`timescale 1ns/1ps
module dfi_cmd_assertions (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic sector_we_r,
    input wire logic [27:0] sector_lba_r,
    input wire logic [15:0] sector_data_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [7:0] rd_addr_r;
    // Read data is judged by the address that was accepted
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_addr_r <= 8'h00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rd_addr_r <= s_axi_araddr;
        end
    end
    chk_zero_fill: assert property (sector_we_r |-> sector_data_r == 16'h0000)
        else $error("sector written with nonzero data");
    chk_lba_native: assert property (sector_we_r |-> sector_lba_r <= 28'h0000FFF)
        else $error("sector written beyond native maximum");
    chk_lba_ascend: assert property (sector_we_r ##1 sector_we_r |-> sector_lba_r == $past(sector_lba_r) + 28'h1)
        else $error("back-to-back sector writes not ascending");
    chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    chk_write_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    chk_busy_drq: assert property (s_axi_rvalid && rd_addr_r == 8'h20 && s_axi_rdata[3] |-> !s_axi_rdata[7])
        else $error("data request shown while busy");
    chk_unmapped_rd: assert property (s_axi_rvalid && rd_addr_r > 8'h28 |-> s_axi_rresp == 2'b10 && s_axi_rdata == 0)
        else $error("unmapped read not refused");
    chk_data_width: assert property (s_axi_rvalid && rd_addr_r == 8'h00 |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("data register wider than one word");
endmodule

/* verification/dfi_host_model.sv */
// Host adapter model driving the task registers over AXI4-Lite
`timescale 1ns/1ps
module dfi_host_model (
    input wire logic clk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    // Each task starts on a fresh edge so no signal is driven twice in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_done = 1'b0;
        logic w_done = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'h1;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clk);
            if (!aw_done && s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (!s_axi_bvalid) @(posedge clk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
endmodule

/* verification/testbench.sv */
// Testbench for the format and identify command block
`timescale 1ns/1ps
module testbench;
    logic clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sector_we_r, drq_seen;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [27:0] sector_lba_r, first_lba, last_lba;
    logic [15:0] sector_data_r;
    logic [31:0] st;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;
    int n_we = 0;
    dfi_cmd u_dut (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sector_we_r, .sector_lba_r,
        .sector_data_r);
    dfi_host_model u_host (.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rvalid, .s_axi_rready);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Media strobe monitor
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches++;
            $display("mismatch cycle_limit expected below 40000 seen %0d", cycles);
            finish_test();
        end
        if (sector_we_r === 1'b1) begin
            if (n_we == 0) first_lba = sector_lba_r;
            last_lba = sector_lba_r;
            n_we++;
        end
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Read with response and data compared under a mask
    task automatic rdc(input logic [7:0] a, input string what, input logic [31:0] exp, input logic [31:0] m);
        u_host.rd(a);
        check(what, exp & m, s_axi_rdata & m);
        check("read response", (a > 8'h28) ? 32'h2 : 32'h0, {30'h0, s_axi_rresp});
    endtask
    // Issue an opcode, then poll until busy clears; note any data request seen
    task automatic run(input logic [7:0] op);
        n_we = 0;
        drq_seen = 1'b0;
        u_host.wr(dfi_pkg::A_COMMAND, {24'h0, op});
        st = 32'h80;
        while (st[7] !== 1'b0) begin
            u_host.rd(dfi_pkg::A_STATUS);
            st = s_axi_rdata;
            if (st[3] === 1'b1) drq_seen = 1'b1;
        end
    endtask
    function automatic logic [16:0] id_exp(input int w, input logic [2:0] cfg);
        if (w == 0) return {1'b1, cfg[1] ? 16'h045E : 16'h045A};
        if (w == 2) return {1'b1, cfg[0] ? 16'h37C8 : 16'h0000};
        if (w == 6) return {1'b1, 16'h003F};
        if (w >= 7 && w <= 9) return {1'b1, 16'h0000};
        if ((w >= 10 && w <= 19) || (w >= 23 && w <= 46)) return {1'b1, dfi_pkg::ID_ASCII_SPACES};
        if (w == 20) return {1'b1, 16'h0003};
        if (w == 21) return {1'b1, dfi_pkg::BUF_UNITS};
        if (w == 47) return {1'b1, 16'h8010};
        if (w == 49) return {1'b1, dfi_pkg::ID_W49 | {2'b00, cfg[2], 13'h0}};
        return 17'h0;
    endfunction
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        logic [16:0] e;
        nrst = 1'b0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        rdc(dfi_pkg::A_STATUS, "status reset", 32'h50, 32'hFF);
        rdc(dfi_pkg::A_CONFIG, "config reset", 32'h01, 32'hFF);
        rdc(dfi_pkg::A_DEFECT, "lists reset", 32'h00, 32'hFF);
        rdc(8'h2C, "unmapped read", 32'h0, 32'hFFFFFFFF);
        u_host.wr(8'h2C, 32'h5A);
        check("unmapped write", 32'h2, {30'h0, s_axi_bresp});
        for (int i = 0; i < 2; i++) begin
            u_host.wr(dfi_pkg::A_CONFIG, i ? 32'h6 : 32'h1);
            run(8'hEC);
            check("identify request", 32'h8, st & 32'h88);
            for (int w = 0; w < 256; w++) begin
                e = id_exp(w, i ? 3'h6 : 3'h1);
                rdc(dfi_pkg::A_DATA, "identify word", {16'h0, e[15:0]}, e[16] ? 32'hFFFF : 32'h0);
            end
            rdc(dfi_pkg::A_STATUS, "identify end", 32'h0, 32'h88);
        end
        u_host.wr(dfi_pkg::A_DATA, 32'h1234);
        u_host.wr(dfi_pkg::A_LBA_LO, 32'hA7);
        u_host.wr(dfi_pkg::A_LBA_MID, 32'h05);
        u_host.wr(dfi_pkg::A_LBA_HI, 32'h00);
        u_host.wr(dfi_pkg::A_DEVHEAD, 32'h40);
        run(8'h50);
        check("track writes", 64, n_we);
        check("track first", 32'h580, {4'h0, first_lba});
        check("track last", 32'h5BF, {4'h0, last_lba});
        check("track status", 32'h0, st & 32'h81);
        rdc(dfi_pkg::A_LBA_LO, "position low", 32'hBF, 32'hFF);
        rdc(dfi_pkg::A_DEVHEAD, "head field", 32'h0, 32'h0F);
        u_host.wr(dfi_pkg::A_LBA_MID, 32'h10);
        u_host.wr(dfi_pkg::A_LBA_LO, 32'h00);
        run(8'h50);
        check("range abort", 32'h1, {31'h0, st[0]} + n_we);
        rdc(dfi_pkg::A_ERROR, "range error", 32'h04, 32'h04);
        u_host.wr(dfi_pkg::A_FEATURE, 32'h12);
        run(8'hF3);
        run(8'hF7);
        rdc(dfi_pkg::A_ERROR, "feature abort", 32'h04, 32'h04);
        u_host.wr(dfi_pkg::A_FEATURE, 32'h11);
        run(8'hF7);
        rdc(dfi_pkg::A_ERROR, "prepare abort", 32'h04, 32'h04);
        check("abort writes", 0, n_we);
        u_host.wr(dfi_pkg::A_DEFECT, 32'h1);
        u_host.wr(dfi_pkg::A_DEFECT, 32'h1);
        check("defect write", 32'h0, {30'h0, s_axi_bresp});
        rdc(dfi_pkg::A_DEFECT, "reassigned", 32'h02, 32'hFF);
        run(8'hF3);
        run(8'hF7);
        check("unit writes", 4096, n_we);
        check("unit span", 32'hFFF, {4'h0, last_lba} + {4'h0, first_lba});
        check("unit no request", 32'h0, {31'h0, drq_seen});
        rdc(dfi_pkg::A_ERROR, "unit error", 32'h0, 32'h04);
        rdc(dfi_pkg::A_DEFECT, "merged lists", 32'h20, 32'hFF);
        finish_test();
    end
endmodule
bind dfi_cmd dfi_cmd_assertions u_chk (.clk, .nrst, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .sector_we_r,
    .sector_lba_r, .sector_data_r);
